// file: design/perf_counter_pkg.sv
// Constants and carrier types for the two performance counters of the memory controller.
// Assumes every user of these names sits on the memory controller clock.
package perf_counter_pkg;

  localparam int CFG_ONE_LSB      = 0;
  localparam int CFG_TWO_LSB      = 16;
  localparam int REGION_EN_ONE    = 14;
  localparam int INIT_EN_ONE      = 15;
  localparam int REGION_EN_TWO    = 30;
  localparam int INIT_EN_TWO      = 31;
  localparam int SEL_REGION_ONE   = 0;
  localparam int SEL_ID_ONE       = 8;
  localparam int SEL_REGION_TWO   = 16;
  localparam int SEL_ID_TWO       = 24;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
  localparam logic [7:0]  AGE_RESET    = 8'h00;

  localparam logic [3:0] EV_ALL       = 4'h0;
  localparam logic [3:0] EV_ACTIVATE  = 4'h1;
  localparam logic [3:0] EV_READ      = 4'h2;
  localparam logic [3:0] EV_WRITE     = 4'h3;
  localparam logic [3:0] EV_FULL      = 4'h4;
  localparam logic [3:0] EV_ELEVATE   = 4'h8;
  localparam logic [3:0] EV_PENDING   = 4'h9;

  localparam logic [3:0] REGION_SDRAM = 4'h0;
  localparam logic [3:0] REGION_REGS  = 4'h7;

  // One command as accepted from the interconnect, with its size in burst units.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       to_regs;
    logic [7:0] initiator;
    logic [7:0] pieces;
  } command_t;

  // Per-counter settings unpacked from the configuration and select words.
  typedef struct packed {
    logic [3:0] code;
    logic       region_en;
    logic       init_en;
    logic [3:0] region;
    logic [7:0] init_id;
  } counter_cfg_t;

endpackage : perf_counter_pkg

// file: design/perf_event_counter.sv
// One 32-bit performance counter with its event selection and filters.
// Assumes event strobes are single-cycle pulses on the memory controller clock.
`timescale 1ns/1ns
module perf_event_counter
(
  input  wire logic                           i_clk,
  input  wire logic                           i_reset,
  input  wire logic                           i_clear,
  input  wire perf_counter_pkg::counter_cfg_t i_cfg,
  input  wire perf_counter_pkg::command_t     i_cmd,
  input  wire perf_counter_pkg::command_t     i_act,
  input  wire logic                           i_full,
  input  wire logic                           i_pending,
  input  wire perf_counter_pkg::command_t     i_elevate,
  output logic [31:0]                         o_count
);

  function automatic logic passes(input perf_counter_pkg::counter_cfg_t c,
                                  input perf_counter_pkg::command_t t);
    logic id_ok;
    logic reg_ok;
    id_ok  = !c.init_en || (t.initiator == c.init_id);
    reg_ok = !c.region_en ||
             ((c.region == perf_counter_pkg::REGION_SDRAM) && !t.to_regs) ||
             ((c.region == perf_counter_pkg::REGION_REGS) && t.to_regs);
    passes = t.valid && id_ok && reg_ok;
  endfunction : passes

  wire logic        cmd_ok  = passes(i_cfg, i_cmd);
  wire logic        act_ok  = passes(i_cfg, i_act);
  wire logic        elev_ok = passes(i_cfg, i_elevate);
  wire logic [31:0] pieces  = {24'h00_0000, i_cmd.pieces};
  logic [31:0]      step;

  always_comb
  begin
    step = 32'h0000_0000;
    case (i_cfg.code)
      perf_counter_pkg::EV_ALL:      step = cmd_ok ? pieces : 32'h0000_0000;
      perf_counter_pkg::EV_ACTIVATE: step = act_ok ? 32'h0000_0001 : 32'h0000_0000;
      perf_counter_pkg::EV_READ:     step = (cmd_ok && !i_cmd.write) ? pieces : 32'h0000_0000;
      perf_counter_pkg::EV_WRITE:    step = (cmd_ok && i_cmd.write) ? pieces : 32'h0000_0000;
      perf_counter_pkg::EV_FULL:     step = i_full ? 32'h0000_0001 : 32'h0000_0000;
      perf_counter_pkg::EV_ELEVATE:  step = elev_ok ? 32'h0000_0001 : 32'h0000_0000;
      perf_counter_pkg::EV_PENDING:  step = i_pending ? 32'h0000_0001 : 32'h0000_0000;
      default:                       step = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_count <= perf_counter_pkg::COUNT_RESET;
    else if (i_clear)
      o_count <= perf_counter_pkg::COUNT_RESET;
    else
      o_count <= o_count + step;
  end

endmodule : perf_event_counter

// file: design/perf_counter_event_select.sv
// Top of the performance counter event selection, with starvation tracking of the oldest command.
// Assumes command, activate and queue signals come from controller logic on the same clock.
`timescale 1ns/1ns
module perf_counter_event_select
(
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic [31:0]                i_counter_config_register,
  input  wire logic [31:0]                i_initiator_region_select_register,
  input  wire logic [7:0]                 i_starvation_transfer_threshold,
  input  wire logic                       i_clear_one,
  input  wire logic                       i_clear_two,
  input  wire perf_counter_pkg::command_t i_cmd,
  input  wire perf_counter_pkg::command_t i_act,
  input  wire logic                       i_queue_full,
  input  wire logic                       i_queue_pending,
  input  wire logic                       i_transfer_done,
  input  wire logic                       i_oldest_new,
  input  wire logic [7:0]                 i_oldest_initiator,
  input  wire logic                       i_oldest_to_regs,
  output logic [31:0]                     o_perf_counter_one,
  output logic [31:0]                     o_perf_counter_two,
  output logic                            o_raise_priority
);

  // Settings are taken straight from the register words so a write steers counting in the same cycle.
  perf_counter_pkg::counter_cfg_t cfg_one;
  perf_counter_pkg::counter_cfg_t cfg_two;
  assign cfg_one.code      = i_counter_config_register[perf_counter_pkg::CFG_ONE_LSB +: 4];
  assign cfg_one.region_en = i_counter_config_register[perf_counter_pkg::REGION_EN_ONE];
  assign cfg_one.init_en   = i_counter_config_register[perf_counter_pkg::INIT_EN_ONE];
  assign cfg_one.region    = i_initiator_region_select_register[perf_counter_pkg::SEL_REGION_ONE +: 4];
  assign cfg_one.init_id   = i_initiator_region_select_register[perf_counter_pkg::SEL_ID_ONE +: 8];
  assign cfg_two.code      = i_counter_config_register[perf_counter_pkg::CFG_TWO_LSB +: 4];
  assign cfg_two.region_en = i_counter_config_register[perf_counter_pkg::REGION_EN_TWO];
  assign cfg_two.init_en   = i_counter_config_register[perf_counter_pkg::INIT_EN_TWO];
  assign cfg_two.region    = i_initiator_region_select_register[perf_counter_pkg::SEL_REGION_TWO +: 4];
  assign cfg_two.init_id   = i_initiator_region_select_register[perf_counter_pkg::SEL_ID_TWO +: 8];

  logic [7:0] age;
  logic       raised;
  wire logic  reach = (i_starvation_transfer_threshold != 8'h00) &&
                      (age >= i_starvation_transfer_threshold);
  wire logic  raise_now = reach && !raised && !i_oldest_new && i_queue_pending;

  // Elevation events are counted once per oldest command, at the moment it is raised.
  perf_counter_pkg::command_t elevate;
  assign elevate.valid     = raise_now;
  assign elevate.write     = 1'b0;
  assign elevate.to_regs   = i_oldest_to_regs;
  assign elevate.initiator = i_oldest_initiator;
  assign elevate.pieces    = 8'h01;

  wire logic [7:0] next_age = i_oldest_new ? perf_counter_pkg::AGE_RESET :
                              ((i_transfer_done && age != 8'hFF) ? age + 8'h01 : age);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      age              <= perf_counter_pkg::AGE_RESET;
      raised           <= 1'b0;
      o_raise_priority <= 1'b0;
    end
    else
    begin
      age              <= next_age;
      raised           <= i_oldest_new ? 1'b0 : (raised || raise_now);
      o_raise_priority <= !i_oldest_new && (raised || raise_now);
    end
  end

  perf_event_counter counter_one
  (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_clear   (i_clear_one),
    .i_cfg     (cfg_one),
    .i_cmd     (i_cmd),
    .i_act     (i_act),
    .i_full    (i_queue_full),
    .i_pending (i_queue_pending),
    .i_elevate (elevate),
    .o_count   (o_perf_counter_one)
  );

  perf_event_counter counter_two
  (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_clear   (i_clear_two),
    .i_cfg     (cfg_two),
    .i_cmd     (i_cmd),
    .i_act     (i_act),
    .i_full    (i_queue_full),
    .i_pending (i_queue_pending),
    .i_elevate (elevate),
    .o_count   (o_perf_counter_two)
  );

endmodule : perf_counter_event_select

// file: tb/perf_counter_event_select_properties.sv
// Assertions on the ports of the performance counter event selection top.
// Assumes one clock domain and the asynchronous active-high reset of the top.
`timescale 1ns/1ns
module perf_counter_event_select_properties
(
  input wire logic                       i_clk,
  input wire logic                       i_reset,
  input wire logic [31:0]                i_counter_config_register,
  input wire logic [31:0]                i_initiator_region_select_register,
  input wire logic                       i_clear_one,
  input wire logic                       i_clear_two,
  input wire perf_counter_pkg::command_t i_cmd,
  input wire perf_counter_pkg::command_t i_act,
  input wire logic                       i_queue_full,
  input wire logic                       i_queue_pending,
  input wire logic                       i_oldest_new,
  input wire logic [31:0]                o_perf_counter_one,
  input wire logic [31:0]                o_perf_counter_two,
  input wire logic                       o_raise_priority
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire [3:0]  code_one = i_counter_config_register[3:0];
  wire [3:0]  code_two = i_counter_config_register[19:16];
  wire [1:0]  filt_one = i_counter_config_register[15:14];
  wire [1:0]  filt_two = i_counter_config_register[31:30];
  wire [31:0] pieces   = {24'h00_0000, i_cmd.pieces};
  wire        one_run  = !i_clear_one && filt_one == 2'h0;
  wire        two_run  = !i_clear_two && filt_two == 2'h0;
  a_read_count:
  assert property (one_run && code_one == 4'h2 && i_cmd.valid && !i_cmd.write |=>
    o_perf_counter_one == $past(o_perf_counter_one) + $past(pieces)) else $error("read count step wrong");
  a_write_count:
  assert property (two_run && code_two == 4'h3 && i_cmd.valid && i_cmd.write |=>
    o_perf_counter_two == $past(o_perf_counter_two) + $past(pieces)) else $error("write count step wrong");
  a_full_cycles:
  assert property (one_run && code_one == 4'h4 && i_queue_full |=>
    o_perf_counter_one == $past(o_perf_counter_one) + 32'h0000_0001) else $error("full cycle not counted");
  a_pending_cycles:
  assert property (two_run && code_two == 4'h9 && i_queue_pending |->
    ##1 o_perf_counter_two == $past(o_perf_counter_two) + 32'h0000_0001) else $error("pending cycle not counted");
  a_activate_count:
  assert property (two_run && code_two == 4'h1 && i_act.valid |=>
    o_perf_counter_two == $past(o_perf_counter_two) + 32'h0000_0001) else $error("activate not counted");
  a_reserved_idle:
  assert property (!i_clear_one && (code_one inside {4'h5, 4'h6, 4'h7} || code_one >= 4'hA) |=>
    $stable(o_perf_counter_one)) else $error("reserved code changed counter");
  a_initiator_filter:
  assert property (!i_clear_one && code_one == 4'h2 && filt_one == 2'h2 && i_cmd.valid
    && i_cmd.initiator != i_initiator_region_select_register[15:8] |=> $stable(o_perf_counter_one))
    else $error("filtered initiator counted");
  a_raise_hold:
  assert property (o_raise_priority && !i_oldest_new |=> o_raise_priority) else $error("raise dropped early");
endmodule : perf_counter_event_select_properties

bind perf_counter_event_select perf_counter_event_select_properties chk (.i_clk, .i_reset,
  .i_counter_config_register, .i_initiator_region_select_register, .i_clear_one, .i_clear_two, .i_cmd, .i_act,
  .i_queue_full,
  .i_queue_pending, .i_oldest_new, .o_perf_counter_one, .o_perf_counter_two, .o_raise_priority);

// file: tb/initiator_model.sv
// Bus initiator seen through the interconnect: issues one command per request.
// Assumes requests are single-cycle; between commands valid, write and to_regs are zero while initiator and pieces toggle, since they are not held.
`timescale 1ns/1ns
module initiator_model
(
  input  wire logic                       i_clk,
  input  wire perf_counter_pkg::command_t i_req,
  output perf_counter_pkg::command_t      o_cmd
);
  initial o_cmd = '0;
  always @(posedge i_clk) o_cmd <= i_req.valid ? i_req : {1'b0, ~o_cmd[15:0]};
endmodule : initiator_model

// file: tb/perf_counter_event_select_bench.sv
// Self-checking bench for the performance counter event selection.
// Assumes the initiator model supplies commands; queue levels come from here.
`timescale 1ns/1ns
module perf_counter_event_select_bench;
  typedef struct packed {logic [3:0] c1; logic [1:0] f1; logic [3:0] c2; logic [1:0] f2; logic w; logic t;
    logic [7:0] id; logic [7:0] p; logic [2:0] afp; logic [7:0] e1; logic [7:0] e2;} row_t;
  logic i_clk = 0, i_reset = 1, i_clear_one = 0, i_clear_two = 0, i_queue_full = 0, i_queue_pending = 0;
  logic i_transfer_done = 0, i_oldest_new = 0, o_raise_priority;
  logic [31:0] i_counter_config_register = '0, o_perf_counter_one, o_perf_counter_two;
  logic [7:0] i_starvation_transfer_threshold = 8'h00, i_oldest_initiator = 8'h00;
  logic i_oldest_to_regs = 0;
  logic [31:0] i_initiator_region_select_register = 32'h2200_1107;
  perf_counter_pkg::command_t req = '0, i_cmd, i_act = '0;
  int errors = 0, tests_run = 0;
  row_t rows [9] = '{
    '{4'h2, 2'h0, 4'h0, 2'h0, 1'h0, 1'h0, 8'h11, 8'h04, 3'h0, 8'h04, 8'h04},
    '{4'h0, 2'h0, 4'h3, 2'h0, 1'h1, 1'h0, 8'h22, 8'h03, 3'h0, 8'h03, 8'h03},
    '{4'h2, 2'h3, 4'h2, 2'h3, 1'h0, 1'h1, 8'h11, 8'h02, 3'h0, 8'h02, 8'h00},
    '{4'h2, 2'h2, 4'h2, 2'h1, 1'h0, 1'h0, 8'h33, 8'h05, 3'h0, 8'h00, 8'h05},
    '{4'h1, 2'h0, 4'h1, 2'h0, 1'h0, 1'h0, 8'h11, 8'h00, 3'h4, 8'h01, 8'h01},
    '{4'h4, 2'h0, 4'h9, 2'h0, 1'h0, 1'h0, 8'h11, 8'h00, 3'h3, 8'h01, 8'h01},
    '{4'h5, 2'h0, 4'hA, 2'h0, 1'h0, 1'h0, 8'h11, 8'h04, 3'h7, 8'h00, 8'h00},
    '{4'hF, 2'h0, 4'h7, 2'h0, 1'h0, 1'h0, 8'h11, 8'h04, 3'h7, 8'h00, 8'h00},
    '{4'h3, 2'h0, 4'h2, 2'h0, 1'h1, 1'h0, 8'h11, 8'h06, 3'h0, 8'h06, 8'h00}};
  always #4 i_clk = ~i_clk;
  initiator_model far (.i_clk, .i_req(req), .o_cmd(i_cmd));
  perf_counter_event_select uut (.i_clk, .i_reset, .i_counter_config_register,
    .i_initiator_region_select_register, .i_starvation_transfer_threshold, .i_clear_one,
    .i_clear_two, .i_cmd, .i_act, .i_queue_full, .i_queue_pending, .i_transfer_done, .i_oldest_new,
    .i_oldest_initiator, .i_oldest_to_regs, .o_perf_counter_one, .o_perf_counter_two, .o_raise_priority);
  task step;
    @(posedge i_clk);
    #1;
  endtask : step
  task check(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task clear_to(logic [31:0] c);
    {i_clear_one, i_clear_two, i_counter_config_register} = {2'h3, c};
    step;
    {i_clear_one, i_clear_two} = 2'h0;
  endtask : clear_to
  initial
  begin
    repeat (12) step;
    i_reset = 0;
    foreach (rows[k])
    begin
      clear_to({rows[k].f2, 10'h000, rows[k].c2, rows[k].f1, 10'h000, rows[k].c1});
      req = {rows[k].p != 8'h00, rows[k].w, rows[k].t, rows[k].id, rows[k].p};
      {i_act.valid, i_queue_full, i_queue_pending} = rows[k].afp;
      step;
      {req, i_act, i_queue_full, i_queue_pending} = '0;
      repeat (3) step;
      check("counter one", {24'h00_0000, rows[k].e1}, o_perf_counter_one);
      check("counter two", {24'h00_0000, rows[k].e2}, o_perf_counter_two);
      $display("row %0d done", k);
    end
    // Counter one watches register accesses only, so the oldest command's region bit decides it.
    clear_to(32'h8008_4008);
    {i_starvation_transfer_threshold, i_oldest_initiator, i_queue_pending, i_oldest_new, i_oldest_to_regs} =
      {16'h0211, 3'h7};
    step;
    {i_oldest_new, i_transfer_done} = 2'h1;
    repeat (2) step;
    i_transfer_done = 0;
    repeat (4) step;
    check("raise", 32'h0000_0001, {31'h0, o_raise_priority});
    check("elevations one", 32'h0000_0001, o_perf_counter_one);
    check("elevations two", 32'h0000_0000, o_perf_counter_two);
    i_oldest_new = 1;
    step;
    i_oldest_new = 0;
    repeat (2) step;
    check("raise after new", 32'h0000_0000, {31'h0, o_raise_priority});
    $display("elevation test done");
    i_reset = 1;
    #1;
    check("counter in reset", 32'h0000_0000, o_perf_counter_one);
    $display("reset test done");
    close_out;
  end
  initial
  begin
    repeat (2000) @(posedge i_clk);
    errors++;
    close_out;
  end
endmodule : perf_counter_event_select_bench
